// ===== input_routing_consts.svh
// Constants for the input polarity and event routing block.
// Included by the package and the design module.
`ifndef INPUT_ROUTING_CONSTS_SVH
`define INPUT_ROUTING_CONSTS_SVH
`define NUM_INPUTS        11
`define LOW_GROUP_BITS    6
`define HIGH_GROUP_BITS   5
`define ADDR_POL_LOW      8'h1b
`define ADDR_POL_HIGH     8'h1c
`define ADDR_ROUTE_LOW    8'h1d
`define ADDR_ROUTE_HIGH   8'h1e
`define REG_RESET         8'h00
`define EXTRA_ROW_BIT     5
`define MASK_LOW_FULL     8'h3f
`define MASK_LOW_SMALL    8'h1f
`define MASK_HIGH         8'h1f
`define IN_ZERO           11'h000
`define FLAG_CLEAR        1'b0
`endif

// ===== input_routing_pkg.sv
// Types for the input polarity and event routing block.
// Assumes the constants header is on the include path.
`include "input_routing_consts.svh"
package input_routing_pkg;
   typedef logic [7:0]                 reg_byte_t;
   typedef logic [`NUM_INPUTS-1:0]     in_vec_t;
endpackage

// ===== input_irq_level_event_routing.sv
// Per-input polarity and event routing for eleven general inputs.
// Assumes a register port from the serial interface core, one byte per
// access, and conditioned pin levels synchronous to clk.
// Functional notes
// - Polarity 0 flags low pin, 1 high.
// - First polarity register: inputs 1-6, bits 0-5.
// - Second polarity register: inputs 7-11, bits 0-4.
// - Input six bits work only with extra row.
// - Routing bit 1 sends activity into FIFO.
// - Routing bits: 0-5 first, 0-4 second register.
// - Routed activity raises shared event interrupt.
// - Routed inputs never raise general input interrupt.
// - Routed events count as key events for unlock.
// - Enabled unrouted met condition raises general input bit.
`timescale 1ns/1ns
`default_nettype none
`include "input_routing_consts.svh"
module input_irq_level_event_routing
   import input_routing_pkg::*;
#(
   parameter bit EXTRA_ROW = 1'b0
) (
   input  wire logic      clk,
   input  wire logic      reset,
   input  wire logic      reg_write,
   input  wire logic      reg_read,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic [7:0]     reg_rdata,
   input  wire logic [10:0] row_pins,
   input  wire logic [10:0] input_irq_enable_bit_n,
   output logic [10:0]    input_level_flag_n,
   output logic [10:0]    fifo_event_valid,
   output logic [10:0]    fifo_event_level,
   output logic           fifo_event_is_key,
   output logic           event_irq_request,
   output logic           input_pin_irq_summary
);

   reg_byte_t pol_low;
   reg_byte_t pol_high;
   reg_byte_t route_low;
   reg_byte_t route_high;
   in_vec_t   input_polarity_bit_n;
   in_vec_t   input_fifo_route_bit_n;
   in_vec_t   prev_pins;
   wire in_vec_t cond_met;
   reg_byte_t low_mask;

   // Mask of writable bits in the first register of each pair.
   assign low_mask = EXTRA_ROW ? `MASK_LOW_FULL : `MASK_LOW_SMALL;

   // Returns the read value of a register address, zero when unmapped.
   function automatic reg_byte_t read_mux(input logic [7:0] a);
      reg_byte_t v;
      v = `REG_RESET;
      unique case (a)
         `ADDR_POL_LOW:    v = pol_low;
         `ADDR_POL_HIGH:   v = pol_high;
         `ADDR_ROUTE_LOW:  v = route_low;
         `ADDR_ROUTE_HIGH: v = route_high;
         default:          v = `REG_RESET;
      endcase
      return v;
   endfunction

   // Register writes; reserved bits are masked so they store nothing.
   always_ff @(posedge clk) begin
      if (reset) begin
         pol_low    <= `REG_RESET;
         pol_high   <= `REG_RESET;
         route_low  <= `REG_RESET;
         route_high <= `REG_RESET;
      end else if (reg_write) begin
         if (reg_addr == `ADDR_POL_LOW)
            pol_low <= reg_wdata & low_mask;
         if (reg_addr == `ADDR_POL_HIGH)
            pol_high <= reg_wdata & `MASK_HIGH;
         if (reg_addr == `ADDR_ROUTE_LOW)
            route_low <= reg_wdata & low_mask;
         if (reg_addr == `ADDR_ROUTE_HIGH)
            route_high <= reg_wdata & `MASK_HIGH;
      end
   end

   // Read data is registered and holds until the next read.
   always_ff @(posedge clk) begin
      if (reset)
         reg_rdata <= `REG_RESET;
      else if (reg_read)
         reg_rdata <= read_mux(reg_addr);
   end

   // Pack register fields into per-input vectors, in row pin order.
   assign input_polarity_bit_n = {pol_high[`HIGH_GROUP_BITS-1:0],
                                  pol_low[`LOW_GROUP_BITS-1:0]};
   assign input_fifo_route_bit_n = {route_high[`HIGH_GROUP_BITS-1:0],
                                    route_low[`LOW_GROUP_BITS-1:0]};

   // Input six only exists when the extra row pin is bonded.
   genvar i;
   generate
      for (i = 0; i < `NUM_INPUTS; i++) begin : g_cond
         if (i == `EXTRA_ROW_BIT) begin : g_extra
            assign cond_met[i] = EXTRA_ROW &&
               (row_pins[i] == input_polarity_bit_n[i]);
         end else begin : g_norm
            assign cond_met[i] =
               (row_pins[i] == input_polarity_bit_n[i]);
         end
      end
   endgenerate

   // Level flags follow the polarity condition of each pin.
   always_ff @(posedge clk) begin
      if (reset)
         input_level_flag_n <= `IN_ZERO;
      else
         input_level_flag_n <= cond_met;
   end

   // Previous pin levels for detecting activity on routed inputs.
   always_ff @(posedge clk) begin
      if (reset)
         prev_pins <= `IN_ZERO;
      else
         prev_pins <= row_pins;
   end

   // Routed inputs report each edge as a FIFO event with its new level.
   always_ff @(posedge clk) begin
      if (reset) begin
         fifo_event_valid <= `IN_ZERO;
         fifo_event_level <= `IN_ZERO;
      end else begin
         fifo_event_valid <= (row_pins ^ prev_pins)
                             & input_fifo_route_bit_n;
         fifo_event_level <= row_pins;
      end
   end

   // Any routed event is tagged as a key event and requests the event irq.
   assign fifo_event_is_key = |fifo_event_valid;
   assign event_irq_request = |fifo_event_valid;

   // General input summary excludes routed inputs entirely.
   always_ff @(posedge clk) begin
      if (reset)
         input_pin_irq_summary <= `FLAG_CLEAR;
      else
         input_pin_irq_summary <= |(cond_met & input_irq_enable_bit_n
                                   & ~input_fifo_route_bit_n);
   end

   // Routed edge produces an event one cycle later.
   property p_route_event;
      @(posedge clk) disable iff (reset)
         (input_fifo_route_bit_n[0] && (row_pins[0] != prev_pins[0]))
         |=> fifo_event_valid[0];
   endproperty
   a_route_event: assert property (p_route_event)
      else $error("routed edge gave no event");

   // Unrouted inputs never make events.
   property p_no_event;
      @(posedge clk) disable iff (reset)
         !input_fifo_route_bit_n[3] |=> !fifo_event_valid[3];
   endproperty
   a_no_event: assert property (p_no_event)
      else $error("unrouted input made an event");

   // Event irq tied to events.
   property p_event_irq;
      @(posedge clk) disable iff (reset)
         fifo_event_valid[7] |-> event_irq_request && fifo_event_is_key;
   endproperty
   a_event_irq: assert property (p_event_irq)
      else $error("event without irq or key tag");

   // Routed-only activity never raises the summary.
   property p_routed_quiet;
      @(posedge clk) disable iff (reset)
         (&input_fifo_route_bit_n) |=> !input_pin_irq_summary;
   endproperty
   a_routed_quiet: assert property (p_routed_quiet)
      else $error("routed input raised summary");

   // Enabled unrouted met condition raises summary next cycle.
   property p_summary;
      @(posedge clk) disable iff (reset)
         (cond_met[1] && input_irq_enable_bit_n[1]
          && !input_fifo_route_bit_n[1]) |=> input_pin_irq_summary;
   endproperty
   a_summary: assert property (p_summary)
      else $error("summary missing");

   // Polarity low flags a low pin.
   property p_polarity;
      @(posedge clk) disable iff (reset)
         (!input_polarity_bit_n[2] && !row_pins[2])
         |=> input_level_flag_n[2];
   endproperty
   a_polarity: assert property (p_polarity)
      else $error("low polarity flag missing");

   // Reserved bits stay zero.
   property p_reserved;
      @(posedge clk) disable iff (reset)
         ((pol_low & ~low_mask) == `REG_RESET)
         && ((route_low & ~low_mask) == `REG_RESET)
         && ((pol_high & ~`MASK_HIGH) == `REG_RESET)
         && ((route_high & ~`MASK_HIGH) == `REG_RESET);
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved bit stored");

   // Without the extra row, input six is never flagged.
   property p_extra;
      @(posedge clk) disable iff (reset)
         !EXTRA_ROW |=> !input_level_flag_n[`EXTRA_ROW_BIT]
                        && !route_low[`EXTRA_ROW_BIT];
   endproperty
   a_extra: assert property (p_extra)
      else $error("input six active without extra row");

   // A write is read back.
   property p_readback;
      @(posedge clk) disable iff (reset)
         (reg_write && reg_addr == `ADDR_POL_HIGH && !reg_read)
         ##1 (reg_read && reg_addr == `ADDR_POL_HIGH && !reg_write)
         |=> reg_rdata == ($past(reg_wdata, 2) & `MASK_HIGH);
   endproperty
   a_readback: assert property (p_readback)
      else $error("readback mismatch");

   // High-group routed edge produces an event one cycle later.
   property p_route_event_high;
      @(posedge clk) disable iff (reset)
         (input_fifo_route_bit_n[10] && (row_pins[10] != prev_pins[10]))
         |=> fifo_event_valid[10];
   endproperty
   a_route_event_high: assert property (p_route_event_high)
      else $error("routed high-group edge gave no event");

   // An event carries the pin level that caused it.
   property p_event_level;
      @(posedge clk) disable iff (reset)
         fifo_event_valid[0] |-> fifo_event_level[0] == $past(row_pins[0]);
   endproperty
   a_event_level: assert property (p_event_level)
      else $error("event level does not match pin");

   // High polarity flags a high pin.
   property p_polarity_high;
      @(posedge clk) disable iff (reset)
         (input_polarity_bit_n[8] && row_pins[8]) |=> input_level_flag_n[8];
   endproperty
   a_polarity_high: assert property (p_polarity_high)
      else $error("high polarity flag missing");

   // A pin away from its polarity level leaves the flag clear.
   property p_flag_clear;
      @(posedge clk) disable iff (reset)
         (input_polarity_bit_n[4] != row_pins[4]) |=> !input_level_flag_n[4];
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("flag set with condition unmet");

   // No enabled unrouted condition leaves the summary low.
   property p_summary_off;
      @(posedge clk) disable iff (reset)
         ((cond_met & input_irq_enable_bit_n & ~input_fifo_route_bit_n)
          == `IN_ZERO) |=> !input_pin_irq_summary;
   endproperty
   a_summary_off: assert property (p_summary_off)
      else $error("summary raised without enabled condition");

   // Event indications are low whenever no event stands.
   property p_event_quiet;
      @(posedge clk) disable iff (reset)
         (fifo_event_valid == `IN_ZERO)
         |-> !event_irq_request && !fifo_event_is_key;
   endproperty
   a_event_quiet: assert property (p_event_quiet)
      else $error("event indication without event");

   // A polarity write lands masked in the next cycle.
   property p_write_pol_low;
      @(posedge clk) disable iff (reset)
         (reg_write && reg_addr == `ADDR_POL_LOW)
         |=> pol_low == ($past(reg_wdata) & low_mask);
   endproperty
   a_write_pol_low: assert property (p_write_pol_low)
      else $error("polarity write did not land");

   // A routing write lands masked in the next cycle.
   property p_write_route_low;
      @(posedge clk) disable iff (reset)
         (reg_write && reg_addr == `ADDR_ROUTE_LOW)
         |=> route_low == ($past(reg_wdata) & low_mask);
   endproperty
   a_write_route_low: assert property (p_write_route_low)
      else $error("routing write did not land");

   // A read returns the register value seen at the read edge.
   property p_read_route_high;
      @(posedge clk) disable iff (reset)
         (reg_read && reg_addr == `ADDR_ROUTE_HIGH)
         |=> reg_rdata == $past(route_high);
   endproperty
   a_read_route_high: assert property (p_read_route_high)
      else $error("routing read returned wrong value");

   // Reset clears every register and output by the next cycle.
   property p_reset_clear;
      @(posedge clk)
         reset |=> (pol_low == `REG_RESET) && (pol_high == `REG_RESET)
                   && (route_low == `REG_RESET) && (route_high == `REG_RESET)
                   && (reg_rdata == `REG_RESET)
                   && (input_level_flag_n == `IN_ZERO)
                   && (fifo_event_valid == `IN_ZERO)
                   && !input_pin_irq_summary;
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("reset left state set");

endmodule // input_irq_level_event_routing
`default_nettype wire

// ===== host_model.sv
// Host processor model: one byte register access at a time.
// Assumes callers enter each task just after a rising clk edge.
`timescale 1ns/1ns
`default_nettype none
module host_model (
   input  wire logic       clk,
   input  wire logic [7:0] reg_rdata,
   output logic            reg_write,
   output logic            reg_read,
   output logic [7:0]      reg_addr,
   output logic [7:0]      reg_wdata
);
   // Idle strobes from time zero.
   initial begin
      reg_write = 1'b0;
      reg_read  = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
   end
   // Write held over the taking edge, then one idle edge.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_write <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_write <= 1'b0;
      @(posedge clk);
   endtask
   // Read data is loaded at the taking edge and held after it.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_read <= 1'b0;
      @(posedge clk);
      d = reg_rdata;
   endtask
   // Write then read of one address on back-to-back edges.
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q);
      reg_write <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_write <= 1'b0;
      reg_read  <= 1'b1;
      @(posedge clk);
      reg_read  <= 1'b0;
      @(posedge clk);
      q = reg_rdata;
   endtask
endmodule // host_model
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the input polarity and routing block.
// Assumes the package, constants header and host model exist.
`timescale 1ns/1ns
`default_nettype none
module tb import input_routing_pkg::*;;
   logic      clk;
   logic      reset;
   logic      wr_s;
   logic      rd_s;
   reg_byte_t addr;
   reg_byte_t wdata;
   reg_byte_t rdata;
   reg_byte_t rv;
   in_vec_t   row_pins;
   in_vec_t   irq_en;
   in_vec_t   flags;
   in_vec_t   ev_valid;
   in_vec_t   ev_level;
   logic      is_key;
   logic      ev_irq;
   logic      summary;
   int        bad_count = 0;
   int        checked = 0;
   int        cycles = 0;
   // Free-running 25 MHz clock.
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   host_model i_host_model (.clk(clk), .reg_rdata(rdata),
      .reg_write(wr_s), .reg_read(rd_s), .reg_addr(addr),
      .reg_wdata(wdata));
   input_irq_level_event_routing #(.EXTRA_ROW(1'b1))
      i_input_irq_level_event_routing (.clk(clk), .reset(reset),
      .reg_write(wr_s), .reg_read(rd_s), .reg_addr(addr),
      .reg_wdata(wdata), .reg_rdata(rdata), .row_pins(row_pins),
      .input_irq_enable_bit_n(irq_en), .input_level_flag_n(flags),
      .fifo_event_valid(ev_valid), .fifo_event_level(ev_level),
      .fifo_event_is_key(is_key), .event_irq_request(ev_irq),
      .input_pin_irq_summary(summary));
   // Counts comparisons and reports any mismatch.
   task automatic chk(input string n, input logic [10:0] e,
                      input logic [10:0] g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask
   // Prints the verdict and ends the run.
   task automatic wrap_up();
      if (bad_count == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Reset values, reserved masking and an unmapped address.
   task automatic test_regs();
      reg_byte_t m [4] = '{8'h3f, 8'h1f, 8'h3f, 8'h1f};
      for (int i = 0; i < 4; i++) begin
         i_host_model.rd(8'h1b + i[7:0], rv);
         chk("reset value", 11'h000, {3'b000, rv});
         i_host_model.wr(8'h1b + i[7:0], 8'hff);
         i_host_model.rd(8'h1b + i[7:0], rv);
         chk("masked", {3'b000, m[i]}, {3'b000, rv});
      end
      i_host_model.wr(8'h1f, 8'hff);
      i_host_model.rd(8'h1f, rv);
      chk("unmapped", 11'h000, {3'b000, rv});
   endtask
   // Both polarities, the summary and its routed exclusion.
   task automatic test_levels();
      i_host_model.wr(8'h1d, 8'h00);
      i_host_model.wr(8'h1e, 8'h00);
      i_host_model.wr(8'h1b, 8'h00);
      irq_en <= 11'h7ff;
      row_pins <= 11'h03f;
      repeat (3) @(posedge clk);
      chk("flags", 11'h000, flags);
      chk("summary", 11'h000, {10'd0, summary});
      row_pins <= 11'h7c0;
      repeat (3) @(posedge clk);
      chk("flags", 11'h7ff, flags);
      chk("summary", 11'h001, {10'd0, summary});
      i_host_model.wr(8'h1d, 8'h3f);
      i_host_model.wr(8'h1e, 8'h1f);
      repeat (2) @(posedge clk);
      chk("summary", 11'h000, {10'd0, summary});
   endtask
   // Toggles pins in m and expects event pulses e for one cycle.
   task automatic pulse(input in_vec_t m, input in_vec_t e);
      row_pins <= row_pins ^ m;
      @(posedge clk);
      #1;
      chk("event", e, ev_valid);
      chk("event irq", {10'd0, |e}, {10'd0, ev_irq});
      chk("key event", {10'd0, |e}, {10'd0, is_key});
      if (|e)
         chk("level", row_pins, ev_level);
      @(posedge clk);
      #1;
      chk("event end", 11'h000, ev_valid);
      @(posedge clk);
   endtask
   // Routed inputs make events, unrouted ones stay silent.
   task automatic test_events();
      i_host_model.wr(8'h1d, 8'h01);
      i_host_model.wr(8'h1e, 8'h10);
      pulse(11'h001, 11'h001);
      pulse(11'h002, 11'h000);
      pulse(11'h400, 11'h400);
      pulse(11'h401, 11'h401);
   endtask
   // Back-to-back write and read, then a mid-run reset.
   task automatic test_reset();
      i_host_model.wr_rd(8'h1c, 8'ha5, rv);
      chk("back to back", 11'h005, {3'b000, rv});
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk("flags in reset", 11'h000, flags);
      chk("events in reset", 11'h000, ev_valid);
      chk("summary in reset", 11'h000, {10'd0, summary});
      @(posedge clk);
      reset <= 1'b0;
      i_host_model.rd(8'h1c, rv);
      chk("reset clears", 11'h000, {3'b000, rv});
   endtask
   // Reset, then the scenarios in order.
   initial begin
      reset = 1'b1;
      row_pins = 11'h000;
      irq_en = 11'h000;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      test_regs();
      test_levels();
      test_events();
      test_reset();
      wrap_up();
   end
   // Cuts a hang short.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         bad_count++;
         wrap_up();
      end
   end
endmodule // tb
`default_nettype wire
